/* acf_map.svh */
// Register offsets, field positions, reset values and codes of the ALU block
`ifndef ACF_MAP_SVH
`define ACF_MAP_SVH

// ----------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------
`define ACF_ADDR_W 12
`define ACF_OFF_INSTR 12'h000
`define ACF_OFF_ACC 12'h004
`define ACF_OFF_FLAGS 12'h008
`define ACF_OFF_STATE 12'h00c
`define ACF_FILE_TAG 3'h1
`define ACF_FILE_TAG_MSB 11
`define ACF_FILE_TAG_LSB 9
`define ACF_FILE_IDX_MSB 8
`define ACF_FILE_IDX_LSB 2

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ACF_INSTR_W 23
`define ACF_FLAGS_W 3
`define ACF_ST_SKIP 0
`define ACF_ST_CYC_LSB 1
`define ACF_ST_DISC 3
`define ACF_NIB_MSB 3
`define ACF_FILE_DEPTH 128
`define ACF_DATA_W 8

// ----------------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------------
`define ACF_ACC_RST 8'h00
`define ACF_FLAGS_RST 3'h0
`define ACF_INSTR_RST 23'h000000
`define ACF_CLEAR_VAL 8'h00
`define ACF_CYC_ONE 2'h1
`define ACF_CYC_TWO 2'h2
`define ACF_RESP_OKAY 2'h0
`define ACF_RESP_DECERR 2'h3

`endif

/* acf_pkg.sv */
// Types shared by the ALU datapath files
package acf_pkg;

    // ------------------------------------------------------------------
    // Operation codes, numbered from zero in this order
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ACF_NOP,
        ACF_ADD_LITERAL_TO_ACC,
        ACF_ADD_ACC_AND_REGISTER,
        ACF_AND_ACC_WITH_REGISTER,
        ACF_AND_LITERAL_WITH_ACC,
        ACF_BIT_CLEAR_REGISTER,
        ACF_BIT_SET_REGISTER,
        ACF_BIT_TEST_SKIP_WHEN_ONE,
        ACF_CLEAR_REGISTER
    } acf_op_t;

    typedef struct packed {
        logic [7:0] literal;
        logic dest;
        logic [2:0] bit_sel;
        logic [6:0] faddr;
        acf_op_t op;
    } acf_instr_t;

    typedef struct packed {
        logic zero_flag;
        logic digit_carry_flag;
        logic carry;
    } acf_flags_t;

    typedef enum logic [1:0] {
        S_IDLE,
        S_EXEC,
        S_NOP,
        S_BUS_RD
    } acf_fsm_t;

endpackage

/* acf_file_mem.sv */
// File register memory with registered read data
`timescale 1ns/1ps
module acf_file_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 128,
    parameter int AW = $clog2(DEPTH)
)
(
    input wire logic clk,
    input wire logic we,
    input wire logic re,
    input wire logic [AW-1:0] addr,
    input wire logic [WIDTH-1:0] wdata,
    output logic [WIDTH-1:0] rdata
);

    logic [WIDTH-1:0] mem [DEPTH];

    // No reset: contents stay undefined until written
    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[addr] <= wdata;
        end
    end

    always_ff @(posedge clk)
    begin
        if (re)
        begin
            rdata <= mem[addr];
        end
    end

endmodule

/* acf_alu_top.sv */
// Accumulator and file register ALU with an AXI4-Lite register slave
`timescale 1ns/1ps
`include "acf_map.svh"
module acf_alu_top
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [`ACF_ADDR_W-1:0] AWADDR,
    input wire logic [2:0] AWPROT,
    input wire logic WVALID,
    output logic WREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    output logic BVALID,
    input wire logic BREADY,
    output logic [1:0] BRESP,
    input wire logic ARVALID,
    output logic ARREADY,
    input wire logic [`ACF_ADDR_W-1:0] ARADDR,
    input wire logic [2:0] ARPROT,
    output logic RVALID,
    input wire logic RREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP
);
    import acf_pkg::*;

    localparam int FA_W = $clog2(`ACF_FILE_DEPTH);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    acf_fsm_t state_r;
    acf_instr_t instr_r;
    acf_instr_t instr_nxt;
    acf_flags_t flags_r;
    acf_flags_t flags_nxt;
    logic [7:0] acc_r;
    logic skip_pend_r;
    logic [1:0] last_cyc_r;
    logic disc_r;

    logic aw_full_r;
    logic w_full_r;
    logic ar_full_r;
    logic [`ACF_ADDR_W-1:0] aw_addr_r;
    logic [`ACF_ADDR_W-1:0] ar_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic awready_r;
    logic wready_r;
    logic arready_r;
    logic bvalid_r;
    logic rvalid_r;
    logic [1:0] bresp_r;
    logic [1:0] rresp_r;
    logic [31:0] rdata_r;

    logic wr_go;
    logic rd_go;
    logic wr_file;
    logic wr_instr;
    logic wr_acc;
    logic wr_flags;
    logic wr_state;
    logic wr_known;
    logic rd_file;
    logic rd_known;
    logic [31:0] reg_rdata;
    logic [31:0] instr_merged;
    logic [31:0] instr_wide;

    logic mem_we;
    logic mem_re;
    logic [FA_W-1:0] mem_addr;
    logic [7:0] mem_wdata;
    logic [7:0] mem_rdata;

    logic [7:0] src;
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] bitmask;
    logic [7:0] res;
    logic to_acc;
    logic to_mem;
    logic skip_take;
    logic is_lit;

    assign AWREADY = awready_r;
    assign WREADY = wready_r;
    assign ARREADY = arready_r;
    assign BVALID = bvalid_r;
    assign BRESP = bresp_r;
    assign RVALID = rvalid_r;
    assign RRESP = rresp_r;
    assign RDATA = rdata_r;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [`ACF_ADDR_W-1:0] a,
                                 input logic [`ACF_ADDR_W-1:0] off);
        hit = (a[`ACF_ADDR_W-1:2] == off[`ACF_ADDR_W-1:2]);
    endfunction

    function automatic logic in_file(input logic [`ACF_ADDR_W-1:0] a);
        in_file = (a[`ACF_FILE_TAG_MSB:`ACF_FILE_TAG_LSB] == `ACF_FILE_TAG);
    endfunction

    // Requests are only served while idle, so an access never races
    // an executing instruction for the single memory port.
    assign wr_go = (state_r == S_IDLE) && aw_full_r && w_full_r && !bvalid_r;
    assign rd_go = (state_r == S_IDLE) && ar_full_r && !rvalid_r && !wr_go;

    assign wr_file = in_file(aw_addr_r);
    assign wr_instr = hit(aw_addr_r, `ACF_OFF_INSTR);
    assign wr_acc = hit(aw_addr_r, `ACF_OFF_ACC);
    assign wr_flags = hit(aw_addr_r, `ACF_OFF_FLAGS);
    assign wr_state = hit(aw_addr_r, `ACF_OFF_STATE);
    assign wr_known = wr_file | wr_instr | wr_acc | wr_flags | wr_state;
    assign rd_file = in_file(ar_addr_r);

    assign instr_wide = {{(32-`ACF_INSTR_W){1'b0}}, instr_r};

    // Byte lanes of an instruction write merge with the last one
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_lane
            assign instr_merged[gi*8 +: 8] = w_strb_r[gi] ?
                w_data_r[gi*8 +: 8] :
                instr_wide[gi*8 +: 8];
        end
    endgenerate

    assign instr_nxt = acf_instr_t'(instr_merged[`ACF_INSTR_W-1:0]);

    always_comb
    begin
        reg_rdata = 32'h00000000;
        rd_known = 1'b1;
        if (hit(ar_addr_r, `ACF_OFF_INSTR))
            reg_rdata = {{(32-`ACF_INSTR_W){1'b0}}, instr_r};
        else if (hit(ar_addr_r, `ACF_OFF_ACC))
            reg_rdata = {24'h000000, acc_r};
        else if (hit(ar_addr_r, `ACF_OFF_FLAGS))
            reg_rdata = {29'h00000000, flags_r};
        else if (hit(ar_addr_r, `ACF_OFF_STATE))
        begin
            reg_rdata[`ACF_ST_SKIP] = skip_pend_r;
            reg_rdata[`ACF_ST_CYC_LSB +: 2] = last_cyc_r;
            reg_rdata[`ACF_ST_DISC] = disc_r;
        end
        else
            rd_known = 1'b0;
    end

    // ------------------------------------------------------------------
    // Execute stage
    // ------------------------------------------------------------------
    assign is_lit = (instr_r.op == ACF_ADD_LITERAL_TO_ACC) ||
                    (instr_r.op == ACF_AND_LITERAL_WITH_ACC);

    always_comb
    begin
        src = is_lit ? instr_r.literal : mem_rdata;
        sum = {1'b0, acc_r} + {1'b0, src};
        nib = {1'b0, acc_r[`ACF_NIB_MSB:0]} +
              {1'b0, src[`ACF_NIB_MSB:0]};
        bitmask = 8'h01 << instr_r.bit_sel;
        res = acc_r;
        to_acc = 1'b0;
        to_mem = 1'b0;
        skip_take = 1'b0;
        flags_nxt = flags_r;
        case (instr_r.op)
            ACF_ADD_LITERAL_TO_ACC:
            begin
                res = sum[7:0];
                to_acc = 1'b1;
                flags_nxt.carry = sum[8];
                flags_nxt.digit_carry_flag = nib[4];
                flags_nxt.zero_flag = (sum[7:0] == 8'h00);
            end
            ACF_ADD_ACC_AND_REGISTER:
            begin
                res = sum[7:0];
                to_acc = !instr_r.dest;
                to_mem = instr_r.dest;
                flags_nxt.carry = sum[8];
                flags_nxt.digit_carry_flag = nib[4];
                flags_nxt.zero_flag = (sum[7:0] == 8'h00);
            end
            ACF_AND_ACC_WITH_REGISTER:
            begin
                res = acc_r & mem_rdata;
                to_acc = !instr_r.dest;
                to_mem = instr_r.dest;
                flags_nxt.zero_flag = (res == 8'h00);
            end
            ACF_AND_LITERAL_WITH_ACC:
            begin
                res = acc_r & instr_r.literal;
                to_acc = 1'b1;
                flags_nxt.zero_flag = (res == 8'h00);
            end
            ACF_BIT_CLEAR_REGISTER:
            begin
                res = mem_rdata & ~bitmask;
                to_mem = 1'b1;
            end
            ACF_BIT_SET_REGISTER:
            begin
                res = mem_rdata | bitmask;
                to_mem = 1'b1;
            end
            ACF_BIT_TEST_SKIP_WHEN_ONE:
            begin
                skip_take = mem_rdata[instr_r.bit_sel];
            end
            ACF_CLEAR_REGISTER:
            begin
                res = `ACF_CLEAR_VAL;
                to_mem = 1'b1;
                flags_nxt.zero_flag = 1'b1;
            end
            default:
            begin
                res = acc_r;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Memory port
    // ------------------------------------------------------------------
    always_comb
    begin
        mem_we = 1'b0;
        mem_re = 1'b0;
        mem_addr = instr_r.faddr;
        mem_wdata = res;
        if (wr_go && wr_file)
        begin
            mem_we = w_strb_r[0];
            mem_addr = aw_addr_r[`ACF_FILE_IDX_MSB:`ACF_FILE_IDX_LSB];
            mem_wdata = w_data_r[7:0];
        end
        else if (wr_go && wr_instr)
        begin
            // Operand fetched now so the execute cycle sees it
            mem_re = 1'b1;
            mem_addr = instr_nxt.faddr;
        end
        else if (rd_go && rd_file)
        begin
            mem_re = 1'b1;
            mem_addr = ar_addr_r[`ACF_FILE_IDX_MSB:`ACF_FILE_IDX_LSB];
        end
        else if (state_r == S_EXEC)
        begin
            mem_we = to_mem;
        end
    end

    acf_file_mem #(
        .WIDTH(`ACF_DATA_W),
        .DEPTH(`ACF_FILE_DEPTH)
    ) u_mem (
        .clk(CLK),
        .we(mem_we),
        .re(mem_re),
        .addr(mem_addr),
        .wdata(mem_wdata),
        .rdata(mem_rdata)
    );

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (RESET)
            state_r <= S_IDLE;
        else
        begin
            case (state_r)
                S_IDLE:
                begin
                    if (wr_go && wr_instr)
                        state_r <= skip_pend_r ? S_NOP : S_EXEC;
                    else if (rd_go && rd_file)
                        state_r <= S_BUS_RD;
                end
                S_EXEC: state_r <= S_IDLE;
                S_NOP: state_r <= S_IDLE;
                S_BUS_RD: state_r <= S_IDLE;
                default: state_r <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
            instr_r <= acf_instr_t'(`ACF_INSTR_RST);
        else if (wr_go && wr_instr)
            instr_r <= instr_nxt;
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
            acc_r <= `ACF_ACC_RST;
        else if (wr_go && wr_acc && w_strb_r[0])
            acc_r <= w_data_r[7:0];
        else if (state_r == S_EXEC && to_acc)
            acc_r <= res;
    end

    // Bit and skip operations leave flags_nxt equal to flags_r
    always_ff @(posedge CLK)
    begin
        if (RESET)
            flags_r <= acf_flags_t'(`ACF_FLAGS_RST);
        else if (wr_go && wr_flags && w_strb_r[0])
            flags_r <= acf_flags_t'(w_data_r[`ACF_FLAGS_W-1:0]);
        else if (state_r == S_EXEC)
            flags_r <= flags_nxt;
    end

    // A taken skip discards the next issued instruction; its NOP slot
    // is the second cycle of the bit test.
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            skip_pend_r <= 1'b0;
            last_cyc_r <= `ACF_CYC_ONE;
            disc_r <= 1'b0;
        end
        else if (state_r == S_EXEC)
        begin
            skip_pend_r <= skip_take;
            last_cyc_r <= skip_take ? `ACF_CYC_TWO : `ACF_CYC_ONE;
            disc_r <= 1'b0;
        end
        else if (state_r == S_NOP)
        begin
            skip_pend_r <= 1'b0;
            disc_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite write channels
    // ------------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            aw_full_r <= 1'b0;
            awready_r <= 1'b1;
            aw_addr_r <= '0;
        end
        else
        begin
            if (AWVALID && awready_r)
            begin
                aw_full_r <= 1'b1;
                awready_r <= 1'b0;
                aw_addr_r <= AWADDR;
            end
            if (wr_go)
                aw_full_r <= 1'b0;
            if (bvalid_r && BREADY)
                awready_r <= 1'b1;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            w_full_r <= 1'b0;
            wready_r <= 1'b1;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
        end
        else
        begin
            if (WVALID && wready_r)
            begin
                w_full_r <= 1'b1;
                wready_r <= 1'b0;
                w_data_r <= WDATA;
                w_strb_r <= WSTRB;
            end
            if (wr_go)
                w_full_r <= 1'b0;
            if (bvalid_r && BREADY)
                wready_r <= 1'b1;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            bvalid_r <= 1'b0;
            bresp_r <= `ACF_RESP_OKAY;
        end
        else if (wr_go)
        begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_known ? `ACF_RESP_OKAY : `ACF_RESP_DECERR;
        end
        else if (bvalid_r && BREADY)
            bvalid_r <= 1'b0;
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read channels
    // ------------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            ar_full_r <= 1'b0;
            arready_r <= 1'b1;
            ar_addr_r <= '0;
        end
        else
        begin
            if (ARVALID && arready_r)
            begin
                ar_full_r <= 1'b1;
                arready_r <= 1'b0;
                ar_addr_r <= ARADDR;
            end
            if (rd_go)
                ar_full_r <= 1'b0;
            if (rvalid_r && RREADY)
                arready_r <= 1'b1;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            rvalid_r <= 1'b0;
            rresp_r <= `ACF_RESP_OKAY;
            rdata_r <= 32'h00000000;
        end
        else if (rd_go && !rd_file)
        begin
            rvalid_r <= 1'b1;
            rdata_r <= reg_rdata;
            rresp_r <= rd_known ? `ACF_RESP_OKAY : `ACF_RESP_DECERR;
        end
        else if (state_r == S_BUS_RD)
        begin
            rvalid_r <= 1'b1;
            rdata_r <= {24'h000000, mem_rdata};
            rresp_r <= `ACF_RESP_OKAY;
        end
        else if (rvalid_r && RREADY)
            rvalid_r <= 1'b0;
    end

endmodule

/* acf_alu_props.sv */
// Bus protocol and result checks for the accumulator ALU block
`timescale 1ns/1ps
`include "acf_map.svh"
module acf_alu_chk
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic AWVALID,
    input wire logic AWREADY,
    input wire logic WVALID,
    input wire logic WREADY,
    input wire logic BVALID,
    input wire logic BREADY,
    input wire logic [1:0] BRESP,
    input wire logic ARVALID,
    input wire logic ARREADY,
    input wire logic [`ACF_ADDR_W-1:0] ARADDR,
    input wire logic RVALID,
    input wire logic RREADY,
    input wire logic [31:0] RDATA,
    input wire logic [1:0] RRESP
);
    // ------------------------------------------------------------------
    // Read address kept so each answer can be judged by its target
    // ------------------------------------------------------------------
    logic [`ACF_ADDR_W-1:0] rd_addr_r;
    logic mapped;
    logic [9:0] rd_word;

    always_ff @(posedge CLK)
    begin
        if (ARVALID && ARREADY)
            rd_addr_r <= ARADDR;
    end
    assign rd_word = rd_addr_r[11:2];
    assign mapped = (rd_addr_r[11:4] == 8'h00) || (rd_addr_r[11:9] == 3'h1);

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_bresp_stands:
        assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write response dropped before accepted");
    a_rdata_stands:
        assert property (RVALID && !RREADY |=>
            RVALID && $stable(RDATA) && $stable(RRESP))
        else $error("read response changed before accepted");
    a_write_answer:
        assert property (AWVALID && AWREADY && WVALID && WREADY |->
            ##[2:4] BVALID)
        else $error("write response late");
    a_read_answer:
        assert property (ARVALID && ARREADY |-> ##[2:5] RVALID)
        else $error("read response late");
    a_take_drops:
        assert property (AWVALID && AWREADY |=> !AWREADY && !BVALID)
        else $error("write address ready stayed high after take");
    a_ready_returns:
        assert property (BVALID && BREADY |-> ##[1:2] (AWREADY && WREADY))
        else $error("write readies did not return");
    a_unmapped_read:
        assert property (RVALID && !mapped |->
            RRESP == `ACF_RESP_DECERR && RDATA == 32'h0)
        else $error("unmapped read not refused");
    a_mapped_read:
        assert property (RVALID && mapped |-> RRESP == `ACF_RESP_OKAY)
        else $error("mapped read refused");
    a_skip_cycles:
        assert property (RVALID && rd_word == 10'h003 && RDATA[0] |->
            RDATA[2:1] == 2'h2 && RDATA[31:4] == 28'h0)
        else $error("pending skip without two cycle count");
    a_flags_width:
        assert property (RVALID && rd_word == 10'h002 |->
            RDATA[31:3] == 29'h0)
        else $error("flag read has stray bits");
endmodule

bind acf_alu_top acf_alu_chk chk_u (.CLK(CLK), .RESET(RESET),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID),
    .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR),
    .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP));

/* acf_alu_top_tb.sv */
// Self-checking bench for the accumulator and file register ALU
`timescale 1ns/1ps
`include "acf_map.svh"
`define ACF_CHK(a, e) \
    begin \
        cmp_count++; \
        if ((a) !== (e)) \
        begin \
            fail_count++; \
            $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); \
        end \
    end
module acf_alu_top_tb;
    import acf_pkg::*;
    localparam logic [1:0] ok = `ACF_RESP_OKAY;
    localparam logic [11:0] a_ins = `ACF_OFF_INSTR;
    localparam logic [11:0] a_acc = `ACF_OFF_ACC;
    localparam logic [11:0] a_flg = `ACF_OFF_FLAGS;
    localparam logic [11:0] a_st = `ACF_OFF_STATE;
    logic CLK = 1'b0;
    logic RESET = 1'b1;
    logic AWVALID = 1'b0;
    logic WVALID = 1'b0;
    logic BREADY = 1'b0;
    logic ARVALID = 1'b0;
    logic RREADY = 1'b0;
    logic [11:0] AWADDR = 12'h000;
    logic [11:0] ARADDR = 12'h000;
    logic [31:0] WDATA = 32'h0;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
    logic [1:0] BRESP, RRESP;
    logic [31:0] RDATA;
    logic [31:0] v;
    logic [1:0] r;
    int fail_count = 0;
    int cmp_count = 0;
    int b;

    always #2.5 CLK = ~CLK;

    acf_alu_top dut_u (.CLK(CLK), .RESET(RESET), .AWVALID(AWVALID),
        .AWREADY(AWREADY), .AWADDR(AWADDR), .AWPROT(3'h0),
        .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(4'hf),
        .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP),
        .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR),
        .ARPROT(3'h0), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA),
        .RRESP(RRESP));

    // ------------------------------------------------------------------
    // Bus access tasks
    // ------------------------------------------------------------------
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
        input logic [1:0] er);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge CLK);
        AWADDR <= a;
        WDATA <= d;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        while (!(aw && w))
        begin
            @(posedge CLK);
            if (!aw && AWREADY === 1'b1)
            begin
                aw = 1'b1;
                AWVALID <= 1'b0;
            end
            if (!w && WREADY === 1'b1)
            begin
                w = 1'b1;
                WVALID <= 1'b0;
            end
        end
        // Late ready keeps the response waiting, so it must stand
        repeat (2) @(posedge CLK);
        BREADY <= 1'b1;
        do @(posedge CLK); while (BVALID !== 1'b1);
        BREADY <= 1'b0;
        `ACF_CHK(BRESP, er);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d,
        output logic [1:0] rr);
        @(posedge CLK);
        ARADDR <= a;
        ARVALID <= 1'b1;
        do @(posedge CLK); while (ARREADY !== 1'b1);
        ARVALID <= 1'b0;
        repeat (2) @(posedge CLK);
        RREADY <= 1'b1;
        do @(posedge CLK); while (RVALID !== 1'b1);
        d = RDATA;
        rr = RRESP;
        RREADY <= 1'b0;
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] rr;
        rd(a, d, rr);
        `ACF_CHK(rr, ok);
        `ACF_CHK(d, e);
    endtask

    function automatic logic [11:0] fadr(input logic [6:0] i);
        return {3'h1, i, 2'h0};
    endfunction

    task automatic ex(input acf_op_t op, input logic [6:0] fa,
        input logic [2:0] bs, input logic dst, input logic [7:0] lit);
        wr(a_ins, {9'h0, lit, dst, bs, fa, op}, ok);
    endtask

    // Literal op: preset flags and accumulator, run, read both back
    task automatic lc(input acf_op_t op, input logic [7:0] fl0, acc0, lit,
        eacc, efl);
        wr(a_flg, {24'h0, fl0}, ok);
        wr(a_acc, {24'h0, acc0}, ok);
        ex(op, 7'h00, 3'h0, 1'b0, lit);
        rdc(a_acc, {24'h0, eacc});
        rdc(a_flg, {24'h0, efl});
    endtask

    // Register op: also preset and read back the file register
    task automatic rc(input acf_op_t op, input logic [6:0] fa,
        input logic dst, input logic [7:0] fl0, acc0, f0, eacc, ef, efl);
        wr(fadr(fa), {24'h0, f0}, ok);
        wr(a_flg, {24'h0, fl0}, ok);
        wr(a_acc, {24'h0, acc0}, ok);
        ex(op, fa, 3'h0, dst, 8'h00);
        rdc(a_acc, {24'h0, eacc});
        rdc(fadr(fa), {24'h0, ef});
        rdc(a_flg, {24'h0, efl});
    endtask

    task automatic finish_test;
        if (fail_count == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Watchdog: the sequence needs well under 2000 cycles
    // ------------------------------------------------------------------
    initial
    begin
        repeat (20000) @(posedge CLK);
        fail_count++;
        finish_test;
    end

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge CLK);
        RESET <= 1'b0;
        rdc(a_acc, 32'h0);
        rdc(a_flg, 32'h0);
        rdc(a_st, 32'h2);
        lc(ACF_ADD_LITERAL_TO_ACC, 8'h0, 8'h0f, 8'h01, 8'h10, 8'h2);
        lc(ACF_ADD_LITERAL_TO_ACC, 8'h7, 8'h10, 8'hf0, 8'h00, 8'h5);
        lc(ACF_ADD_LITERAL_TO_ACC, 8'h0, 8'h01, 8'hff, 8'h00, 8'h7);
        lc(ACF_ADD_LITERAL_TO_ACC, 8'h7, 8'h22, 8'h33, 8'h55, 8'h0);
        lc(ACF_AND_LITERAL_WITH_ACC, 8'h3, 8'hf0, 8'h0f, 8'h0, 8'h7);
        lc(ACF_AND_LITERAL_WITH_ACC, 8'h7, 8'h5a, 8'hff, 8'h5a, 8'h3);
        rc(ACF_ADD_ACC_AND_REGISTER, 7'h7f, 1'b0, 8'h4, 8'h88, 8'h88,
            8'h10, 8'h88, 8'h3);
        rc(ACF_ADD_ACC_AND_REGISTER, 7'h00, 1'b1, 8'h4, 8'h01, 8'h0f,
            8'h01, 8'h10, 8'h2);
        rc(ACF_AND_ACC_WITH_REGISTER, 7'h05, 1'b0, 8'h3, 8'hcc, 8'h33,
            8'h00, 8'h33, 8'h7);
        rc(ACF_AND_ACC_WITH_REGISTER, 7'h7f, 1'b1, 8'h7, 8'hcc, 8'hf0,
            8'hcc, 8'hc0, 8'h3);
        rc(ACF_CLEAR_REGISTER, 7'h09, 1'b0, 8'h0, 8'h5a, 8'ha5,
            8'h5a, 8'h00, 8'h4);
        wr(a_flg, 32'h5, ok);
        for (b = 0; b < 8; b++)
        begin
            wr(fadr(7'h21), 32'h00, ok);
            ex(ACF_BIT_SET_REGISTER, 7'h21, b[2:0], 1'b0, 8'h00);
            rdc(fadr(7'h21), 32'h1 << b);
            wr(fadr(7'h21), 32'hff, ok);
            ex(ACF_BIT_CLEAR_REGISTER, 7'h21, b[2:0], 1'b0, 8'h00);
            rdc(fadr(7'h21), 32'hff ^ (32'h1 << b));
        end
        rdc(a_flg, 32'h5);
        wr(fadr(7'h28), 32'h80, ok);
        wr(a_acc, 32'h10, ok);
        wr(a_flg, 32'h0, ok);
        ex(ACF_BIT_TEST_SKIP_WHEN_ONE, 7'h28, 3'h7, 1'b0, 8'h00);
        rdc(a_st, 32'h5);
        ex(ACF_ADD_LITERAL_TO_ACC, 7'h00, 3'h0, 1'b0, 8'h01);
        rdc(a_acc, 32'h10);
        rdc(a_flg, 32'h0);
        rd(a_st, v, r);
        `ACF_CHK(v & 32'h9, 32'h8);
        ex(ACF_ADD_LITERAL_TO_ACC, 7'h00, 3'h0, 1'b0, 8'h01);
        rdc(a_acc, 32'h11);
        ex(ACF_BIT_TEST_SKIP_WHEN_ONE, 7'h28, 3'h6, 1'b0, 8'h00);
        rdc(a_st, 32'h2);
        ex(ACF_ADD_LITERAL_TO_ACC, 7'h00, 3'h0, 1'b0, 8'h01);
        rdc(a_acc, 32'h12);
        rd(12'h010, v, r);
        `ACF_CHK(r, `ACF_RESP_DECERR);
        `ACF_CHK(v, 32'h0);
        wr(12'h100, 32'h55, `ACF_RESP_DECERR);
        rdc(a_acc, 32'h12);
        wr(a_st, 32'hf, ok);
        ex(ACF_NOP, 7'h00, 3'h0, 1'b0, 8'hff);
        rdc(a_acc, 32'h12);
        rdc(a_flg, 32'h0);
        rdc(a_st, 32'h2);
        finish_test;
    end
endmodule
